// >>> src/mfs_frame_stats.sv
// Per-frame pixel statistics: feature count, pixel sum and brightest pixel.
`timescale 1ns/1ps
`default_nettype none
`include "mfs_params.svh"
module mfs_frame_stats import mfs_pkg::*; #(
  parameter int PIXELS = `MFS_PIXELS
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       pix_valid_i,
  input  wire logic [5:0] pix_data_i,
  input  wire logic       pix_feature_i,
  output mfs_stats_type   stats_o
);
  logic [15:0] sum_reg;
  logic [9:0]  feat_reg;
  logic [5:0]  max_reg;
  logic [15:0] idx_reg;
  logic [15:0] sum_now;
  logic [9:0]  feat_now;
  logic [5:0]  max_now;
  assign sum_now  = sum_reg + {10'h000, pix_data_i};
  assign feat_now = feat_reg + ((pix_feature_i && feat_reg != 10'h3FF) ? 10'h001 : 10'h000);
  assign max_now  = (pix_data_i > max_reg) ? pix_data_i : max_reg;
  // Frame accumulation; results publish on the last pixel of a frame.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sum_reg <= 16'h0000; feat_reg <= 10'h000; max_reg <= 6'h00;
      idx_reg <= 16'h0000; stats_o <= '0;
    end else if (pix_valid_i) begin
      if (idx_reg == 16'(PIXELS - 1)) begin
        sum_reg <= 16'h0000; feat_reg <= 10'h000; max_reg <= 6'h00;
        idx_reg <= 16'h0000;
        stats_o.intensity <= sum_now[15:8]; // RULE_14 RULE_15
        stats_o.quality <= (feat_now[9:2] > `MFS_QUALITY_MAX) ?
                           `MFS_QUALITY_MAX : feat_now[9:2]; // RULE_13
        stats_o.brightest <= {2'b00, max_now}; // RULE_16
      end else begin
        sum_reg <= sum_now; feat_reg <= feat_now; max_reg <= max_now;
        idx_reg <= idx_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/mfs_params.svh
// Address map, field positions, reset values and limits of the motion readout.
`ifndef MFS_PARAMS_SVH
`define MFS_PARAMS_SVH
`define MFS_ADDR_MOTION   7'h02
`define MFS_ADDR_DX       7'h03
`define MFS_ADDR_DY       7'h04
`define MFS_ADDR_QUALITY  7'h05
`define MFS_ADDR_SUM      7'h06
`define MFS_ADDR_BRIGHT   7'h07
`define MFS_ADDR_RSVD_A   7'h08
`define MFS_ADDR_RSVD_B   7'h09
`define MFS_ADDR_CFG      7'h0A
`define MFS_ADDR_FLUSH    7'h12
`define MFS_CFG_RESET     8'h09
`define MFS_CFG_RSVD_MASK 8'h0F
`define MFS_CFG_GATE_BIT  6
`define MFS_CFG_TEST_BIT  5
`define MFS_CFG_RES_BIT   4
`define MFS_ST_MOT_BIT    7
`define MFS_ST_OVF_BIT    4
`define MFS_ST_RES_BIT    0
`define MFS_DRAIN_LO      16
`define MFS_DRAIN_HI      64
`define MFS_STEP_MAX      127
`define MFS_ACC_W         15
`define MFS_PIXELS        900
`define MFS_QUALITY_MAX   8'hA9
`define MFS_BYTE_BITS     4'h8
`define MFS_WR_BIT        7
`endif

// >>> src/mfs_pkg.sv
// Types shared by the serial port, the frame statistics and the register file.
package mfs_pkg;
  // One decoded serial access, read or write.
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } mfs_access_type;
  // Statistics of the last completed frame, as the registers show them.
  typedef struct packed {
    logic [7:0] quality;
    logic [7:0] intensity;
    logic [7:0] brightest;
  } mfs_stats_type;
  // Serial port phases.
  typedef enum {
    MFS_SER_ADDR,
    MFS_SER_RD_WAIT,
    MFS_SER_RD_SHIFT,
    MFS_SER_WR_SHIFT
  } mfs_ser_state_type;
endpackage

// >>> src/mfs_regs.sv
// Motion and frame statistics register file behind the serial port.
//
// Contract
// RULE_01 - Status read freezes X and Y snapshots.
// RULE_02 - Controller reads status before X, Y.
// RULE_03 - Second status read discards unread snapshots.
// RULE_04 - Controller reads 0x02..0x04 in order.
// RULE_05 - Wide accumulators; overflow loses excess, flags.
// RULE_06 - Overflow clears after read, not full-scale.
// RULE_07 - Excess keeps motion flag; snapshot saturates.
// RULE_08 - Controller repeats reads until motion clear.
// RULE_09 - Drain within 16 or 64 reads.
// RULE_10 - Any flush write clears all motion.
// RULE_11 - X register reports, clears on read.
// RULE_12 - Y register reports, clears on read.
// RULE_13 - Quality is count over four, max 169.
// RULE_14 - Intensity is pixel sum high byte.
// RULE_15 - Intensity ranges zero to 221.
// RULE_16 - Brightest pixel six bits, top zero.
// RULE_17 - Config layout: gating, test, resolution.
// RULE_18 - Status bit 7 shows pending motion.
// RULE_19 - Status bit 4 shows overflow.
// RULE_20 - Resolution bit, mirrored in status bit 0.
// RULE_21 - All access over the serial port.
// RULE_22 - Addresses 0x08, 0x09 read zero.
// RULE_23 - Snapshot subtracts from accumulator, keeps residue.
`timescale 1ns/1ps
`default_nettype none
`include "mfs_params.svh"
module mfs_regs import mfs_pkg::*; #(
  parameter int PIXELS = `MFS_PIXELS, // Pixels per frame.
  parameter int ACC_W  = `MFS_ACC_W   // Accumulator width, signed.
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ncs_n_i,
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic            miso_oe_n_o,
  input  wire logic       motion_valid_i,
  input  wire logic [7:0] motion_dx_i,
  input  wire logic [7:0] motion_dy_i,
  input  wire logic       pix_valid_i,
  input  wire logic [5:0] pix_data_i,
  input  wire logic       pix_feature_i,
  output logic            illumination_gating_o,
  output logic            resolution_select_o,
  output logic            self_test_start_o
);

  // Accumulator limits; each read drains at most one full step up, or one step plus one down.
  localparam logic signed [ACC_W-1:0] LIM_LO =
    ACC_W'(`MFS_DRAIN_LO * `MFS_STEP_MAX);
  localparam logic signed [ACC_W-1:0] LIM_HI =
    ACC_W'(`MFS_DRAIN_HI * `MFS_STEP_MAX);
  localparam logic signed [ACC_W-1:0] STEP =
    ACC_W'(`MFS_STEP_MAX);
  // Configuration reset value, so single fields can be picked from it.
  localparam logic [7:0] CFG_RST = `MFS_CFG_RESET;

  // Decoded access from the serial port.
  mfs_access_type acc;
  logic           acc_valid;
  // Registered read answer, handed back to the port.
  logic [7:0]     rd_data_reg;
  // Statistics of the last frame.
  mfs_stats_type  stats;

  // Internal accumulators, wider than the reporting registers.
  logic signed [ACC_W-1:0] acc_x_reg, acc_x_next;
  logic signed [ACC_W-1:0] acc_y_reg, acc_y_next;
  // Frozen snapshots that the X and Y registers return.
  logic signed [7:0] snap_x_reg, snap_x_next;
  logic signed [7:0] snap_y_reg, snap_y_next;
  // Sticky overflow flag.
  logic accumulator_overflow_reg;
  // Configuration fields that software writes.
  logic illumination_gating_reg;
  logic resolution_select_reg;
  logic self_test_reg;

  // The serial port is the only way in.
  mfs_serial_port u_port ( // RULE_21
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .ncs_n_i     (ncs_n_i),
    .sclk_i      (sclk_i),
    .mosi_i      (mosi_i),
    .rd_data_i   (rd_data_reg),
    .acc_o       (acc),
    .acc_valid_o (acc_valid),
    .miso_o      (miso_o),
    .miso_oe_n_o (miso_oe_n_o)
  );

  // Frame statistics engine.
  mfs_frame_stats #(
    .PIXELS (PIXELS)
  ) u_stats (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .pix_valid_i   (pix_valid_i),
    .pix_data_i    (pix_data_i),
    .pix_feature_i (pix_feature_i),
    .stats_o       (stats)
  );

  // Access strobes.
  logic rd_status, rd_dx, rd_dy, wr_flush, wr_cfg;
  assign rd_status = acc_valid && !acc.wr && acc.addr == `MFS_ADDR_MOTION;
  assign rd_dx     = acc_valid && !acc.wr && acc.addr == `MFS_ADDR_DX;
  assign rd_dy     = acc_valid && !acc.wr && acc.addr == `MFS_ADDR_DY;
  assign wr_flush  = acc_valid && acc.wr && acc.addr == `MFS_ADDR_FLUSH;
  assign wr_cfg    = acc_valid && acc.wr && acc.addr == `MFS_ADDR_CFG;

  // Current full-scale limit follows the resolution.
  logic signed [ACC_W-1:0] lim;
  assign lim = resolution_select_reg ? LIM_HI : LIM_LO; // RULE_09

  // Clamp an accumulator to one reportable byte.
  function automatic logic signed [7:0] clamp8(
    input logic signed [ACC_W-1:0] a
  );
    if (a > STEP) begin
      return 8'sh7F; // RULE_07
    end else if (a < -STEP - ACC_W'(1)) begin
      return 8'sh80; // RULE_07
    end
    return a[7:0];
  endfunction

  // Raw next accumulator value, one bit wider so nothing wraps.
  function automatic logic signed [ACC_W:0] grow(
    input logic signed [ACC_W-1:0] a,
    input logic signed [7:0]       taken,
    input logic signed [7:0]       d
  );
    return (ACC_W+1)'(a) - (ACC_W+1)'(taken) + (ACC_W+1)'(d);
  endfunction

  // Saturate a grown value at the current limit.
  function automatic logic signed [ACC_W-1:0] sat(
    input logic signed [ACC_W:0]   g,
    input logic signed [ACC_W-1:0] l
  );
    if (g > (ACC_W+1)'(l)) begin
      return l;
    end else if (g < -(ACC_W+1)'(l)) begin
      return -l;
    end
    return g[ACC_W-1:0];
  endfunction

  // True when a value sits at or beyond full scale.
  function automatic logic at_full(
    input logic signed [ACC_W:0]   g,
    input logic signed [ACC_W-1:0] l
  );
    return (g >= (ACC_W+1)'(l)) || (g <= -(ACC_W+1)'(l));
  endfunction

  // Amounts taken into the snapshot on a status read.
  logic signed [7:0] take_x, take_y, in_x, in_y;
  logic signed [ACC_W:0] grow_x, grow_y;
  logic ovf_event;
  always_comb begin
    take_x = rd_status ? clamp8(acc_x_reg) : 8'sh00; // RULE_01
    take_y = rd_status ? clamp8(acc_y_reg) : 8'sh00; // RULE_01
    in_x   = motion_valid_i ? motion_dx_i : 8'sh00;
    in_y   = motion_valid_i ? motion_dy_i : 8'sh00;
    // Flush drops stored motion but keeps what arrives this cycle.
    grow_x = wr_flush ? grow('0, 8'sh00, in_x) : grow(acc_x_reg, take_x, in_x);
    grow_y = wr_flush ? grow('0, 8'sh00, in_y) : grow(acc_y_reg, take_y, in_y);
    // Beyond the limit the extra path is lost.
    ovf_event = (grow_x > (ACC_W+1)'(lim)) || (grow_x < -(ACC_W+1)'(lim)) ||
                (grow_y > (ACC_W+1)'(lim)) || (grow_y < -(ACC_W+1)'(lim)); // RULE_05
    acc_x_next = sat(grow_x, lim); // RULE_05 RULE_23
    acc_y_next = sat(grow_y, lim); // RULE_05 RULE_23
  end

  // Accumulators; residue left after a snapshot carries forward.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_x_reg <= '0;
      acc_y_reg <= '0;
    end else begin
      acc_x_reg <= acc_x_next; // RULE_23
      acc_y_reg <= acc_y_next; // RULE_23
    end
  end

  // Snapshots: a status read overwrites them, a data read clears the one it returns.
  always_comb begin
    snap_x_next = snap_x_reg;
    snap_y_next = snap_y_reg;
    if (wr_flush) begin
      snap_x_next = 8'sh00; // RULE_10
      snap_y_next = 8'sh00; // RULE_10
    end else if (rd_status) begin
      // Unread values from before are simply replaced.
      snap_x_next = take_x; // RULE_01 RULE_03
      snap_y_next = take_y; // RULE_01 RULE_03
    end else if (rd_dx) begin
      snap_x_next = 8'sh00; // RULE_11
    end else if (rd_dy) begin
      snap_y_next = 8'sh00; // RULE_12
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      snap_x_reg <= 8'sh00;
      snap_y_reg <= 8'sh00;
    end else begin
      snap_x_reg <= snap_x_next;
      snap_y_reg <= snap_y_next;
    end
  end

  // Overflow flag: a new overflow wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      accumulator_overflow_reg <= 1'b0;
    end else if (ovf_event) begin
      accumulator_overflow_reg <= 1'b1; // RULE_05
    end else if (wr_flush) begin
      accumulator_overflow_reg <= 1'b0; // RULE_10
    end else if ((rd_dx || rd_dy) && !at_full(grow_x, lim) &&
                 !at_full(grow_y, lim)) begin
      accumulator_overflow_reg <= 1'b0; // RULE_06
    end
  end

  // Configuration; the self-test bit is a one-cycle trigger.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      illumination_gating_reg <= CFG_RST[`MFS_CFG_GATE_BIT];
      resolution_select_reg   <= CFG_RST[`MFS_CFG_RES_BIT];
      self_test_reg           <= 1'b0;
    end else begin
      self_test_reg <= wr_cfg && acc.data[`MFS_CFG_TEST_BIT]; // RULE_17
      if (wr_cfg) begin
        illumination_gating_reg <= acc.data[`MFS_CFG_GATE_BIT]; // RULE_17
        resolution_select_reg   <= acc.data[`MFS_CFG_RES_BIT]; // RULE_20
      end
    end
  end
  assign illumination_gating_o = illumination_gating_reg;
  assign resolution_select_o   = resolution_select_reg;
  assign self_test_start_o     = self_test_reg;

  // Read mux, sampled from state before this access updates it.
  logic [7:0] rd_value;
  always_comb begin
    rd_value = 8'h00;
    unique case (acc.addr)
      `MFS_ADDR_MOTION: begin
        rd_value[`MFS_ST_MOT_BIT] = acc_x_reg != '0 || acc_y_reg != '0; // RULE_18 RULE_07
        rd_value[`MFS_ST_OVF_BIT] = accumulator_overflow_reg; // RULE_19
        rd_value[`MFS_ST_RES_BIT] = resolution_select_reg; // RULE_20
      end
      `MFS_ADDR_DX:      rd_value = snap_x_reg; // RULE_11
      `MFS_ADDR_DY:      rd_value = snap_y_reg; // RULE_12
      `MFS_ADDR_QUALITY: rd_value = stats.quality; // RULE_13
      `MFS_ADDR_SUM:     rd_value = stats.intensity; // RULE_14
      `MFS_ADDR_BRIGHT:  rd_value = stats.brightest; // RULE_16
      `MFS_ADDR_CFG: begin
        rd_value = `MFS_CFG_RESET & `MFS_CFG_RSVD_MASK; // RULE_17
        rd_value[`MFS_CFG_GATE_BIT] = illumination_gating_reg;
        rd_value[`MFS_CFG_TEST_BIT] = self_test_reg;
        rd_value[`MFS_CFG_RES_BIT]  = resolution_select_reg;
      end
      // Reserved and unmapped addresses answer zero.
      default:           rd_value = 8'h00; // RULE_22
    endcase
  end

  // Read answer register, loaded only on a read access.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_reg <= 8'h00;
    end else if (acc_valid && !acc.wr) begin
      rd_data_reg <= rd_value;
    end
  end

  // Checks on the register behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_freeze_snap: assert property ( // RULE_01
    rd_status |=> snap_x_reg == clamp8($past(acc_x_reg)) &&
                  snap_y_reg == clamp8($past(acc_y_reg)))
    else $error("snapshot not frozen on status read");

  a_discard_old: assert property ( // RULE_03
    rd_status && snap_x_reg != 8'sh00 |=> snap_x_reg == clamp8($past(acc_x_reg)))
    else $error("stale snapshot kept over second status read");

  a_x_clear: assert property ( // RULE_11
    rd_dx |=> snap_x_reg == 8'sh00 && rd_data_reg == $past(snap_x_reg))
    else $error("X register not returned and cleared");

  a_y_clear: assert property ( // RULE_12
    rd_dy |=> snap_y_reg == 8'sh00 && rd_data_reg == $past(snap_y_reg))
    else $error("Y register not returned and cleared");

  a_ovf_set: assert property ( // RULE_05
    ovf_event |=> accumulator_overflow_reg)
    else $error("overflow flag missed");

  a_ovf_clear: assert property ( // RULE_06
    accumulator_overflow_reg && rd_dx && !ovf_event && !at_full(grow_x, lim)
      && !at_full(grow_y, lim) |=> !accumulator_overflow_reg)
    else $error("overflow flag not cleared");

  a_acc_bound: assert property ( // RULE_09
    acc_x_reg <= LIM_HI && acc_x_reg >= -LIM_HI &&
    acc_y_reg <= LIM_HI && acc_y_reg >= -LIM_HI)
    else $error("accumulator beyond drain limit");

  a_acc_low_res: assert property ( // RULE_09
    !resolution_select_reg && !$past(resolution_select_reg) |->
      acc_x_reg <= LIM_LO && acc_x_reg >= -LIM_LO &&
      acc_y_reg <= LIM_LO && acc_y_reg >= -LIM_LO)
    else $error("accumulator beyond low resolution drain limit");

  a_flush_all: assert property ( // RULE_10
    wr_flush && !motion_valid_i |=> acc_x_reg == '0 && acc_y_reg == '0 &&
                                   snap_x_reg == 8'sh00 && snap_y_reg == 8'sh00)
    else $error("flush left motion behind");

  a_status_bits: assert property ( // RULE_20 RULE_19
    rd_status |=> rd_data_reg[`MFS_ST_RES_BIT] == $past(resolution_select_reg) &&
      rd_data_reg[`MFS_ST_OVF_BIT] == $past(accumulator_overflow_reg))
    else $error("status bits wrong");

  a_stats_range: assert property ( // RULE_13 RULE_16
    stats.quality <= `MFS_QUALITY_MAX && stats.brightest[7:6] == 2'b00)
    else $error("frame statistic out of range");

  a_rsvd_zero: assert property ( // RULE_22
    acc_valid && !acc.wr && (acc.addr == `MFS_ADDR_RSVD_A ||
      acc.addr == `MFS_ADDR_RSVD_B) |=> rd_data_reg == 8'h00)
    else $error("reserved address read nonzero");

  a_cfg_top: assert property ( // RULE_17
    acc_valid && !acc.wr && acc.addr == `MFS_ADDR_CFG |=> !rd_data_reg[7])
    else $error("config bit 7 not zero");

endmodule
`default_nettype wire

// >>> src/mfs_serial_port.sv
// Four-wire serial slave: samples the pins, decodes accesses, shifts read data out.
`timescale 1ns/1ps
`default_nettype none
`include "mfs_params.svh"
module mfs_serial_port import mfs_pkg::*; (
  input  wire logic     clk_i,
  input  wire logic     sys_rst_i,
  input  wire logic     ncs_n_i,
  input  wire logic     sclk_i,
  input  wire logic     mosi_i,
  input  wire logic [7:0] rd_data_i,
  output mfs_access_type acc_o,
  output logic          acc_valid_o,
  output logic          miso_o,
  output logic          miso_oe_n_o
);
  // Three-stage synchronisers; the first stage feeds only the second.
  logic [2:0] ncs_s, sclk_s, mosi_s;
  logic       ncs_reg, sclk_reg, mosi_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  mfs_ser_state_type st_reg;
  // A level counts once stages two and three agree.
  function automatic logic filt(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ncs_s <= 3'h7; sclk_s <= 3'h7; mosi_s <= 3'h0;
      ncs_reg <= 1'b1; sclk_reg <= 1'b1; mosi_reg <= 1'b0;
    end else begin
      ncs_s <= {ncs_s[1:0], ncs_n_i}; sclk_s <= {sclk_s[1:0], sclk_i};
      mosi_s <= {mosi_s[1:0], mosi_i};
      ncs_reg <= filt(ncs_s, ncs_reg); sclk_reg <= filt(sclk_s, sclk_reg);
      mosi_reg <= filt(mosi_s, mosi_reg);
    end
  end
  // Edges of the filtered serial clock, only while selected.
  logic rise, fall;
  assign rise = !ncs_reg && !sclk_reg && filt(sclk_s, sclk_reg);
  assign fall = !ncs_reg && sclk_reg && !filt(sclk_s, sclk_reg);
  // Access sequencer; deselect always returns to address phase.
  always_ff @(posedge clk_i) begin
    acc_valid_o <= 1'b0;
    if (sys_rst_i || ncs_reg) begin
      st_reg <= MFS_SER_ADDR; cnt_reg <= 4'h0; sh_reg <= 8'h00;
      acc_o <= '0; miso_o <= 1'b0; miso_oe_n_o <= 1'b1;
    end else begin
      unique case (st_reg)
        MFS_SER_ADDR, MFS_SER_WR_SHIFT: if (rise) begin
          sh_reg <= {sh_reg[6:0], mosi_reg};
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `MFS_BYTE_BITS - 4'h1) begin
            cnt_reg <= 4'h0;
            if (st_reg == MFS_SER_WR_SHIFT) begin
              acc_o.data <= {sh_reg[6:0], mosi_reg}; acc_valid_o <= 1'b1;
              st_reg <= MFS_SER_ADDR;
            end else begin
              acc_o.wr <= sh_reg[6]; acc_o.addr <= {sh_reg[5:0], mosi_reg};
              acc_o.data <= 8'h00;
              acc_valid_o <= !sh_reg[6];
              st_reg <= sh_reg[6] ? MFS_SER_WR_SHIFT : MFS_SER_RD_WAIT;
            end
          end
        end
        // The answer register loads one edge after the strobe, so the load
        // waits one more edge; an earlier load would ship the previous answer.
        MFS_SER_RD_WAIT: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg != 4'h0) begin
            sh_reg <= rd_data_i; miso_o <= rd_data_i[7]; miso_oe_n_o <= 1'b0;
            cnt_reg <= 4'h0; st_reg <= MFS_SER_RD_SHIFT;
          end
        end
        MFS_SER_RD_SHIFT: if (fall) begin
          sh_reg <= {sh_reg[6:0], 1'b0}; miso_o <= sh_reg[6];
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `MFS_BYTE_BITS - 4'h1) begin
            cnt_reg <= 4'h0; miso_oe_n_o <= 1'b1; st_reg <= MFS_SER_ADDR;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/mfs_host_model.sv
// Controller model that frames byte accesses on the four-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module mfs_host_model (
  input  wire logic clk_i,
  output logic      ncs_n_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_n_i
);
  // Deselected, with the serial clock parked high between frames.
  initial begin
    ncs_n_o = 1'b1;
    sclk_o  = 1'b1;
    mosi_o  = 1'b1;
  end

  // One bit: falling edge carries new data, rising edge 12 cycles later.
  task automatic bit_out(input logic b);
    @(posedge clk_i);
    sclk_o <= 1'b0;
    mosi_o <= b;
    repeat (12) @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (13) @(posedge clk_i);
  endtask

  // One whole access, address byte then data byte; every register goes this way.
  task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic oe_ok);
    logic [15:0] frame;
    int          i;
    frame = {wr, addr, wdata};
    rdata = 8'h00;
    oe_ok = 1'b1;
    @(posedge clk_i);
    ncs_n_o <= 1'b0;
    for (i = 15; i >= 8; i--) bit_out(frame[i]);
    if (wr) begin
      for (i = 7; i >= 0; i--) bit_out(frame[i]);
    end else begin
      // The slave needs at least 100 ns before the first data fall.
      repeat (20) @(posedge clk_i);
      for (i = 7; i >= 0; i--) begin
        #1;
        rdata[i] = miso_i;
        oe_ok    = oe_ok & ~miso_oe_n_i;
        bit_out(~mosi_o);
      end
    end
    repeat (8) @(posedge clk_i);
    ncs_n_o <= 1'b1;
    mosi_o  <= ~mosi_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_mfs_regs.sv
// Self-checking bench for the motion and frame statistics registers.
`timescale 1ns/1ps
`default_nettype none
`include "mfs_params.svh"
module tb_mfs_regs import mfs_pkg::*;;
  localparam int NPIX = 16; // Short frames keep the run brief.
  logic       clk, sys_rst, ncs_n, sclk, mosi, miso, miso_oe_n, miso_w;
  logic       motion_valid, pix_valid, pix_feature, gating, res_o, self_test, st_seen;
  logic [7:0] motion_dx, motion_dy;
  logic [5:0] pix_data;
  int         err_count, checks_done, cycles, seed, ax, ay, sx, sy, i, n;
  logic       ovf, res, p;
  logic [7:0] v;

  // Released output shows the inverse, so a stale bit never passes.
  assign miso_w = miso_oe_n ? ~miso : miso;

  mfs_regs #(.PIXELS(NPIX)) u_dut (
    .clk_i(clk), .sys_rst_i(sys_rst), .ncs_n_i(ncs_n), .sclk_i(sclk), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_n_o(miso_oe_n), .motion_valid_i(motion_valid),
    .motion_dx_i(motion_dx), .motion_dy_i(motion_dy), .pix_valid_i(pix_valid),
    .pix_data_i(pix_data), .pix_feature_i(pix_feature), .illumination_gating_o(gating),
    .resolution_select_o(res_o), .self_test_start_o(self_test));
  mfs_host_model u_host (
    .clk_i(clk), .ncs_n_o(ncs_n), .sclk_o(sclk), .mosi_o(mosi),
    .miso_i(miso_w), .miso_oe_n_i(miso_oe_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The trigger is a single-cycle pulse, so it is latched here.
  always @(posedge clk) if (self_test) st_seen <= 1'b1;
  // Hang guard: the planned traffic needs well under this many cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      test_done;
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.access(1'b0, a, 8'h00, d, ok);
    check8({7'h00, ok}, 8'h01);
    check8(d, exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    logic       ok;
    u_host.access(1'b1, a, d, dummy, ok);
  endtask
  function automatic int clamp(input int x, input int m);
    return (x > m) ? m : ((x < -m) ? -m : x);
  endfunction
  // A snapshot byte saturates at the two's complement full scales.
  function automatic int snap8(input int x);
    return (x > 127) ? 127 : ((x < -128) ? -128 : x);
  endfunction
  // One motion report from the frame engine, mirrored in the model.
  task automatic move(input int dx, input int dy);
    int lim;
    lim = res ? 8128 : 2032;
    @(posedge clk);
    motion_valid <= 1'b1;
    motion_dx    <= dx[7:0];
    motion_dy    <= dy[7:0];
    @(posedge clk);
    motion_valid <= 1'b0;
    if (clamp(ax + dx, lim) != ax + dx || clamp(ay + dy, lim) != ay + dy) ovf = 1'b1;
    ax = clamp(ax + dx, lim);
    ay = clamp(ay + dy, lim);
  endtask
  // Status read: flags, then the snapshot leaves its residue behind.
  task automatic status_rd(output logic pend);
    pend = (ax != 0) || (ay != 0);
    rd_chk(`MFS_ADDR_MOTION, {pend, 2'b00, ovf, 3'b000, res});
    sx = snap8(ax);
    sy = snap8(ay);
    ax -= sx;
    ay -= sy;
  endtask
  task automatic xy_rd;
    rd_chk(`MFS_ADDR_DX, sx[7:0]);
    sx = 0;
    if (clamp(ax, res ? 8127 : 2031) == ax &&
        clamp(ay, res ? 8127 : 2031) == ay) ovf = 1'b0;
    rd_chk(`MFS_ADDR_DY, sy[7:0]);
    sy = 0;
  endtask
  // One frame of pixels, then the three statistics against the model.
  task automatic frame(input logic all_max);
    int         k, sum, feat, mx;
    logic [5:0] px;
    logic       f;
    sum  = 0;
    feat = 0;
    mx   = 0;
    for (k = 0; k < NPIX; k++) begin
      px = all_max ? 6'h3F : 6'($random(seed));
      f  = all_max | 1'($random(seed));
      @(posedge clk);
      pix_valid   <= 1'b1;
      pix_data    <= px;
      pix_feature <= f;
      sum += px;
      feat += f;
      if (px > mx) mx = px;
    end
    @(posedge clk);
    pix_valid <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(`MFS_ADDR_QUALITY, 8'(feat / 4));
    rd_chk(`MFS_ADDR_SUM, 8'(sum >> 8));
    rd_chk(`MFS_ADDR_BRIGHT, 8'(mx));
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    seed = 32'h1E0958E0;
    {err_count, checks_done, cycles, ax, ay, sx, sy} = '0;
    {ovf, res, st_seen, motion_valid, pix_valid, pix_feature} = '0;
    {motion_dx, motion_dy, pix_data} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(`MFS_ADDR_CFG, `MFS_CFG_RESET);
    rd_chk(`MFS_ADDR_QUALITY, 8'h00);
    wr(`MFS_ADDR_RSVD_A, 8'($random(seed)));
    rd_chk(`MFS_ADDR_RSVD_A, 8'h00);
    rd_chk(`MFS_ADDR_RSVD_B, 8'h00);
    v = 8'($random(seed)) & 8'hDF;
    wr(`MFS_ADDR_CFG, v);
    rd_chk(`MFS_ADDR_CFG, {1'b0, v[6], 1'b0, v[4], 4'h9});
    check8({6'h00, gating, res_o}, {6'h00, v[6], v[4]});
    wr(`MFS_ADDR_CFG, 8'h20);
    check8({7'h00, st_seen}, 8'h01);
    frame(1'b0);
    frame(1'b1);
    for (i = 0; i < 6; i++) begin
      move($random(seed) % 41, $random(seed) % 41);
      status_rd(p);
      xy_rd;
    end
    // A second status read drops the first snapshot; a repeat read gives zero.
    move(30, -20);
    status_rd(p);
    move(5, 5);
    status_rd(p);
    xy_rd;
    xy_rd;
    // At 1600 cpi a negative pile drains through negative full scale in two reports.
    wr(`MFS_ADDR_CFG, 8'h10);
    res = 1'b1;
    move(-100, -100);
    move(-100, -100);
    status_rd(p);
    xy_rd;
    status_rd(p);
    xy_rd;
    wr(`MFS_ADDR_CFG, 8'h00);
    res = 1'b0;
    // Flood X past the 400 cpi limit, then drain in report cycles.
    for (i = 0; i < 30; i++) move(127, 0);
    n = 0;
    status_rd(p);
    while (p && n < 70) begin
      xy_rd;
      n++;
      status_rd(p);
    end
    check8(8'(n), 8'h10);
    for (i = 0; i < 20; i++) move(127, -127);
    wr(`MFS_ADDR_FLUSH, 8'($random(seed)));
    {ax, ay, sx, sy, ovf} = '0;
    status_rd(p);
    xy_rd;
    test_done;
  end
endmodule
`default_nettype wire
